// file: overload_freq_detect.sv
// Overload early warning, second current and frequency detection, display scaling
`timescale 1ns/1ps
module overload_freq_detect
  import overload_freq_pkg::*;
#(
  parameter int TICK_CYCLES = DELAY_STEP_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fan_pump_variant,
  input wire logic motor2_select,
  input wire logic [SEL_W-1:0] early_warning_select,
  input wire logic thermal_warn,
  input wire logic [CUR_W-1:0] output_current,
  input wire logic [FREQ_W-1:0] output_freq,
  input wire logic [CUR_W-1:0] overload_warn_level,
  input wire logic [DELAY_W-1:0] overload_warn_delay,
  input wire logic [CUR_W-1:0] second_current_level,
  input wire logic [FREQ_W-1:0] second_freq_level,
  input wire logic [FREQ_W-1:0] freq_detect_hysteresis,
  input wire logic coef_write,
  input wire logic signed [COEF_W-1:0] display_scale_a_in,
  input wire logic signed [COEF_W-1:0] display_scale_b_in,
  input wire logic [PID_W-1:0] pid_target,
  input wire logic [PID_W-1:0] pid_feedback,
  output logic overload_warn,
  output logic second_current_detect,
  output logic second_freq_detect,
  output logic signed [COEF_W-1:0] display_scale_a,
  output logic signed [COEF_W-1:0] display_scale_b,
  output logic signed [DISP_W-1:0] speed_display,
  output logic signed [DISP_W-1:0] pid_target_display,
  output logic signed [DISP_W-1:0] pid_feedback_display
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [CUR_W-1:0] clamp_level(input logic [CUR_W-1:0] lvl,
                                                   input logic fan);
    logic [CUR_W-1:0] hi;
    hi = fan ? CUR_LEVEL_MAX_FAN : CUR_LEVEL_MAX_GENERAL;
    if (lvl < CUR_LEVEL_MIN)
      clamp_level = CUR_LEVEL_MIN;
    else if (lvl > hi)
      clamp_level = hi;
    else
      clamp_level = lvl;
  endfunction

  // Cross-multiplied so no divider is needed for the 90 % point
  function automatic logic below_release(input logic [CUR_W-1:0] cur,
                                         input logic [CUR_W-1:0] lvl);
    logic [CUR_W+3:0] lhs;
    logic [CUR_W+3:0] rhs;
    lhs = cur * RELEASE_DEN;
    rhs = lvl * RELEASE_NUM;
    below_release = lhs < rhs;
  endfunction

  function automatic logic signed [COEF_W-1:0] clamp_coef(
    input logic signed [COEF_W-1:0] c,
    input logic signed [COEF_W-1:0] lo,
    input logic signed [COEF_W-1:0] hi);
    if (c < lo)
      clamp_coef = lo;
    else if (c > hi)
      clamp_coef = hi;
    else
      clamp_coef = c;
  endfunction

  // value scaled between B and A: value * (A - B) / full + B
  function automatic logic signed [DISP_W-1:0] pid_scale(
    input logic [PID_W-1:0] v,
    input logic signed [COEF_W-1:0] a,
    input logic signed [COEF_W-1:0] b);
    logic signed [DISP_W+15:0] prod;
    prod = $signed({1'b0, v}) * (a - b);
    pid_scale = DISP_W'(prod / PID_FULL) + DISP_W'(b);
  endfunction

  // ----------------------------------------
  // Effective levels
  // ----------------------------------------
  logic [CUR_W-1:0] warn_level;
  logic [CUR_W-1:0] cur2_level;
  logic [FREQ_W-1:0] freq_level;
  logic [FREQ_W-1:0] freq_release;
  logic [DELAY_W-1:0] delay_steps;

  always_comb
  begin
    warn_level = clamp_level(overload_warn_level, fan_pump_variant);
    cur2_level = clamp_level(second_current_level, 1'b0);
    if (fan_pump_variant && second_freq_level > FREQ_LEVEL_MAX_FAN)
      freq_level = FREQ_LEVEL_MAX_FAN;
    else if (second_freq_level > FREQ_LEVEL_MAX_GENERAL)
      freq_level = FREQ_LEVEL_MAX_GENERAL;
    else
      freq_level = second_freq_level;
    // Saturate so a wide hysteresis cannot wrap the release point
    if (freq_detect_hysteresis > freq_level)
      freq_release = '0;
    else
      freq_release = freq_level - freq_detect_hysteresis;
    if (overload_warn_delay < DELAY_MIN)
      delay_steps = DELAY_MIN;
    else if (overload_warn_delay > DELAY_MAX)
      delay_steps = DELAY_MAX;
    else
      delay_steps = overload_warn_delay;
  end

  // ----------------------------------------
  // 0.1 s tick
  // ----------------------------------------
  logic [31:0] tick_count;
  logic tick;
  logic timing;

  // Tick restarts with each timing run so the delay is not short by a step
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      tick_count <= '0;
    else if (!timing || tick_count == 32'(TICK_CYCLES - 1))
      tick_count <= '0;
    else
      tick_count <= tick_count + 32'h1;
  end

  assign tick = timing && (tick_count == 32'(TICK_CYCLES - 1));

  // ----------------------------------------
  // Thermal warning synchroniser
  // ----------------------------------------
  // Relay contact is asynchronous to core_clk, so two stages before any use
  logic thermal_meta;
  logic thermal_sync;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      thermal_meta <= 1'b0;
      thermal_sync <= 1'b0;
    end
    else
    begin
      thermal_meta <= thermal_warn;
      thermal_sync <= thermal_meta;
    end
  end

  // ----------------------------------------
  // Overload early warning
  // ----------------------------------------
  warn_state_t warn_state;
  logic [DELAY_W-1:0] delay_count;
  logic warn_enable;
  logic at_level;
  logic released;

  assign warn_enable = !motor2_select && early_warning_select == SEL_CURRENT;
  assign at_level = output_current >= warn_level;
  assign released = below_release(output_current, warn_level);
  assign timing = warn_state == WARN_TIMING;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      warn_state <= WARN_IDLE;
      delay_count <= '0;
    end
    else if (!warn_enable)
    begin
      warn_state <= WARN_IDLE;
      delay_count <= '0;
    end
    else
    begin
      case (warn_state)
        WARN_IDLE:
        begin
          delay_count <= '0;
          if (at_level)
            warn_state <= WARN_TIMING;
        end
        WARN_TIMING:
        begin
          if (released)
          begin
            warn_state <= WARN_IDLE;
            delay_count <= '0;
          end
          else if (tick && delay_count + 10'h1 >= delay_steps)
            warn_state <= WARN_ACTIVE;
          else if (tick)
            delay_count <= delay_count + 10'h1;
        end
        WARN_ACTIVE:
        begin
          if (released)
            warn_state <= WARN_IDLE;
        end
        default:
          warn_state <= WARN_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      overload_warn <= 1'b0;
    else if (motor2_select)
      overload_warn <= 1'b0;
    else if (early_warning_select == SEL_THERMAL)
      overload_warn <= thermal_sync;  // Untimed source, not qualified by the delay
    else
      overload_warn <= warn_enable && warn_state == WARN_ACTIVE;
  end

  // ----------------------------------------
  // Second current and frequency detection
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      second_current_detect <= 1'b0;
    else if (output_current >= cur2_level)
      second_current_detect <= 1'b1;
    else if (below_release(output_current, cur2_level))
      second_current_detect <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      second_freq_detect <= 1'b0;
    else if (output_freq >= freq_level)
      second_freq_detect <= 1'b1;
    else if (output_freq < freq_release)
      second_freq_detect <= 1'b0;
  end

  // ----------------------------------------
  // Display coefficients
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      display_scale_a <= COEF_RESET;
      display_scale_b <= '0;
    end
    else if (coef_write)
    begin
      display_scale_a <= clamp_coef(display_scale_a_in, COEF_MIN, COEF_MAX);
      display_scale_b <= clamp_coef(display_scale_b_in, COEF_MIN, COEF_MAX);
    end
  end

  // ----------------------------------------
  // Display conversion
  // ----------------------------------------
  logic signed [COEF_W-1:0] speed_coef;
  logic signed [DISP_W+15:0] speed_prod;

  assign speed_coef = clamp_coef(display_scale_a, SPEED_COEF_MIN, SPEED_COEF_MAX);
  assign speed_prod = $signed({1'b0, output_freq}) * speed_coef;

  // Load and line speed share this value; result in 0.01 units
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      speed_display <= '0;
    else
      speed_display <= DISP_W'(speed_prod / COEF_SCALE);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pid_target_display <= '0;
      pid_feedback_display <= '0;
    end
    else
    begin
      pid_target_display <= pid_scale(pid_target, display_scale_a, display_scale_b);
      pid_feedback_display <= pid_scale(pid_feedback, display_scale_a, display_scale_b);
    end
  end

endmodule

// file: overload_freq_pkg.sv
// Constants shared by the overload and frequency level detection block
// Function
// - Warning level 5-200%, or 5-150% fan variant
// - Release level detection below 90% of level
// - Early warning held off with motor two
// - Qualifying timer only when select equals one
// - Warn after level held for 0.1-60 s
// - Second frequency flag at level, 0-120 Hz fan
// - Frequency release uses shared hysteresis width
// - Second current flag at own 5-200% level
// - Coefficients signed hundredths, -999.00 to +999.00
// - Coefficients convert speeds and controller values
// - Speed uses coefficient A clamped 0.01-200.00
package overload_freq_pkg;

  // ----------------------------------------
  // Clock and timer base
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint DELAY_STEP_PS = 64'd100_000_000_000;  // 0.1 s per delay step
  localparam int DELAY_STEP_CYCLES = int'(DELAY_STEP_PS / CLK_PERIOD_PS);

  // ----------------------------------------
  // Current levels, units of 0.1 % of rated current
  // ----------------------------------------
  localparam int CUR_W = 16;
  localparam logic [CUR_W-1:0] CUR_LEVEL_MIN = 16'h0032;        // 5.0 %
  localparam logic [CUR_W-1:0] CUR_LEVEL_MAX_GENERAL = 16'h07d0; // 200.0 %
  localparam logic [CUR_W-1:0] CUR_LEVEL_MAX_FAN = 16'h05dc;     // 150.0 %
  localparam logic [3:0] RELEASE_NUM = 4'h9;                    // 90 % = 9 / 10
  localparam logic [3:0] RELEASE_DEN = 4'ha;

  // ----------------------------------------
  // Delay, units of 0.1 s
  // ----------------------------------------
  localparam int DELAY_W = 10;
  localparam logic [DELAY_W-1:0] DELAY_MIN = 10'h001;  // 0.1 s
  localparam logic [DELAY_W-1:0] DELAY_MAX = 10'h258;  // 60.0 s

  // ----------------------------------------
  // Frequency, units of 0.01 Hz
  // ----------------------------------------
  localparam int FREQ_W = 16;
  localparam logic [FREQ_W-1:0] FREQ_LEVEL_MAX_FAN = 16'h2ee0;  // 120.00 Hz
  localparam logic [FREQ_W-1:0] FREQ_LEVEL_MAX_GENERAL = 16'hffff;

  // ----------------------------------------
  // Early warning source selection
  // ----------------------------------------
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] SEL_THERMAL = 2'h0;
  localparam logic [SEL_W-1:0] SEL_CURRENT = 2'h1;

  // ----------------------------------------
  // Display coefficients, signed hundredths
  // ----------------------------------------
  localparam int COEF_W = 18;
  localparam logic signed [COEF_W-1:0] COEF_MIN = -18'sd99900;  // -999.00
  localparam logic signed [COEF_W-1:0] COEF_MAX = 18'sd99900;   // +999.00
  localparam logic signed [COEF_W-1:0] COEF_RESET = 18'sd100;   // 1.00
  localparam logic signed [COEF_W-1:0] SPEED_COEF_MIN = 18'sd1;     // 0.01
  localparam logic signed [COEF_W-1:0] SPEED_COEF_MAX = 18'sd20000; // 200.00
  localparam int COEF_SCALE = 100;
  localparam int PID_W = 14;
  localparam int PID_FULL = 10000;  // controller value 100.00 % full scale
  localparam int DISP_W = 32;

  typedef enum logic [1:0] {
    WARN_IDLE,
    WARN_TIMING,
    WARN_ACTIVE
  } warn_state_t;

endpackage

// file: overload_freq_props.sv
// Concurrent checks on the detection block ports
`timescale 1ns/1ps
module overload_freq_props
  import overload_freq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fan_pump_variant,
  input wire logic motor2_select,
  input wire logic [SEL_W-1:0] early_warning_select,
  input wire logic thermal_warn,
  input wire logic [CUR_W-1:0] output_current,
  input wire logic [FREQ_W-1:0] output_freq,
  input wire logic [CUR_W-1:0] second_current_level,
  input wire logic [FREQ_W-1:0] second_freq_level,
  input wire logic [FREQ_W-1:0] freq_detect_hysteresis,
  input wire logic coef_write,
  input wire logic signed [COEF_W-1:0] display_scale_a_in,
  input wire logic overload_warn,
  input wire logic second_current_detect,
  input wire logic second_freq_detect,
  input wire logic signed [COEF_W-1:0] display_scale_a
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_motor2_blocks: assert property (
    motor2_select |=> !overload_warn) else $error("warning with second motor set");
  a_thermal_pass: assert property (
    early_warning_select == SEL_THERMAL && !motor2_select |=> overload_warn == $past(thermal_warn, 3))
    else $error("thermal source not passed through");
  a_cur_set: assert property (
    second_current_level >= CUR_LEVEL_MIN && output_current >= second_current_level
    |=> second_current_detect)
    else $error("current flag not set at level");
  a_cur_release: assert property (
    second_current_level <= CUR_LEVEL_MAX_GENERAL
    && 32'(output_current) * 10 < 32'(second_current_level) * 9 |=> !second_current_detect)
    else $error("current flag held below release");
  a_freq_set: assert property (
    output_freq >= second_freq_level |=> second_freq_detect) else $error("freq flag not set");
  a_freq_release: assert property (
    !fan_pump_variant && 32'(output_freq) + 32'(freq_detect_hysteresis) < 32'(second_freq_level)
    |=> !second_freq_detect) else $error("freq flag held below hysteresis band");
  a_coef_load: assert property (
    coef_write && display_scale_a_in <= COEF_MAX && display_scale_a_in >= COEF_MIN
    |=> display_scale_a == $past(display_scale_a_in)) else $error("coefficient not loaded");
  a_coef_hold: assert property (
    !coef_write |=> $stable(display_scale_a)) else $error("coefficient changed unwritten");
endmodule

bind overload_freq_detect overload_freq_props u_props (.core_clk, .rstn, .fan_pump_variant,
  .motor2_select, .early_warning_select, .thermal_warn, .output_current, .output_freq,
  .second_current_level, .second_freq_level, .freq_detect_hysteresis, .coef_write,
  .display_scale_a_in, .overload_warn, .second_current_detect, .second_freq_detect,
  .display_scale_a);

// file: motor_model.sv
// Behavioural motor load presenting measured current and frequency
`timescale 1ns/1ps
module motor_model
  import overload_freq_pkg::*;
(
  input wire logic core_clk,
  input wire logic [CUR_W-1:0] cur_cmd,
  input wire logic [FREQ_W-1:0] freq_cmd,
  output logic [CUR_W-1:0] output_current,
  output logic [FREQ_W-1:0] output_freq
);
  // One sample of sensing lag, like a real measurement chain
  always_ff @(posedge core_clk)
  begin
    output_current <= cur_cmd;
    output_freq <= freq_cmd;
  end
endmodule

// file: overload_freq_detect_tb.sv
// Self-checking bench for the overload and frequency detection block
`timescale 1ns/1ps
module overload_freq_detect_tb;
  import overload_freq_pkg::*;
  logic core_clk, rstn, fan_pump_variant, motor2_select, thermal_warn, coef_write;
  logic [SEL_W-1:0] early_warning_select;
  logic [CUR_W-1:0] cur_cmd, output_current, overload_warn_level, second_current_level;
  logic [FREQ_W-1:0] freq_cmd, output_freq, second_freq_level, freq_detect_hysteresis;
  logic [DELAY_W-1:0] overload_warn_delay;
  logic signed [COEF_W-1:0] display_scale_a_in, display_scale_b_in;
  logic signed [COEF_W-1:0] display_scale_a, display_scale_b;
  logic [PID_W-1:0] pid_target, pid_feedback;
  logic overload_warn, second_current_detect, second_freq_detect;
  logic signed [DISP_W-1:0] speed_display, pid_target_display, pid_feedback_display;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  motor_model u_motor (.core_clk, .cur_cmd, .freq_cmd, .output_current, .output_freq);
  // Short tick keeps the 0.1 s delay steps at 4 cycles
  overload_freq_detect #(.TICK_CYCLES(4)) u_dut (.core_clk, .rstn, .fan_pump_variant,
    .motor2_select, .early_warning_select, .thermal_warn, .output_current, .output_freq,
    .overload_warn_level, .overload_warn_delay, .second_current_level, .second_freq_level,
    .freq_detect_hysteresis, .coef_write, .display_scale_a_in, .display_scale_b_in,
    .pid_target, .pid_feedback, .overload_warn, .second_current_detect, .second_freq_detect,
    .display_scale_a, .display_scale_b, .speed_display, .pid_target_display,
    .pid_feedback_display);

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Guards against a hang; the full run needs about 125 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic t_warn;
    early_warning_select = SEL_CURRENT;
    overload_warn_delay = 10'h002;
    cur_cmd = 16'h03e8;
    cy(10);
    chk("warn early", 32'h0, overload_warn);
    cy(3);
    chk("warn due", 32'h1, overload_warn);
    cur_cmd = 16'h0385;
    cy(4);
    chk("warn held", 32'h1, overload_warn);
    cur_cmd = 16'h0383;
    cy(4);
    chk("warn released", 32'h0, overload_warn);
    cur_cmd = 16'h03e8;
    cy(5);
    cur_cmd = 16'h0320;
    cy(2);
    cur_cmd = 16'h03e8;
    cy(10);
    chk("warn restarted", 32'h0, overload_warn);
    cy(3);
    chk("warn after restart", 32'h1, overload_warn);
    $display("t_warn done");
  endtask

  task automatic t_block;
    cur_cmd = 16'h0000;
    cy(4);
    motor2_select = 1'b1;
    cur_cmd = 16'h03e8;
    cy(16);
    chk("warn motor2", 32'h0, overload_warn);
    motor2_select = 1'b0;
    early_warning_select = SEL_THERMAL;
    thermal_warn = 1'b1;
    cy(4);
    chk("warn thermal", 32'h1, overload_warn);
    early_warning_select = 2'h2;
    cy(16);
    chk("warn select off", 32'h0, overload_warn);
    thermal_warn = 1'b0;
    early_warning_select = SEL_CURRENT;
    overload_warn_delay = 10'h001;
    fan_pump_variant = 1'b1;
    overload_warn_level = 16'h0708;
    cur_cmd = 16'h0640;
    cy(12);
    chk("warn fan clamp", 32'h1, overload_warn);
    fan_pump_variant = 1'b0;
    cy(4);
    chk("warn general level", 32'h0, overload_warn);
    $display("t_block done");
  endtask

  task automatic t_levels;
    cur_cmd = 16'h07d0;
    freq_cmd = 16'h1770;
    cy(3);
    chk("cur2 set", 32'h1, second_current_detect);
    chk("freq2 set", 32'h1, second_freq_detect);
    cur_cmd = 16'h0708;
    freq_cmd = 16'h157c;
    cy(3);
    chk("cur2 held", 32'h1, second_current_detect);
    chk("freq2 held", 32'h1, second_freq_detect);
    cur_cmd = 16'h0707;
    freq_cmd = 16'h157b;
    cy(3);
    chk("cur2 released", 32'h0, second_current_detect);
    chk("freq2 released", 32'h0, second_freq_detect);
    fan_pump_variant = 1'b1;
    second_freq_level = 16'h32c8;
    freq_cmd = 16'h2ee0;
    cy(3);
    chk("freq2 fan clamp", 32'h1, second_freq_detect);
    fan_pump_variant = 1'b0;
    $display("t_levels done");
  endtask

  task automatic t_coef;
    freq_cmd = 16'h0064;
    display_scale_a_in = 18'sd100000;
    display_scale_b_in = -18'sd100000;
    coef_write = 1'b1;
    cy(1);
    coef_write = 1'b0;
    cy(2);
    chk("scale a clamp", 32'h0001863c, display_scale_a);
    chk("scale b clamp", 32'hfffe79c4, display_scale_b);
    chk("speed max", 32'h00004e20, speed_display);
    chk("pid target", 32'h0001863c, pid_target_display);
    chk("pid feedback", 32'hfffe79c4, pid_feedback_display);
    display_scale_a_in = -18'sd5;
    coef_write = 1'b1;
    cy(1);
    coef_write = 1'b0;
    cy(2);
    chk("speed min", 32'h00000001, speed_display);
    $display("t_coef done");
  endtask

  initial
  begin
    rstn = 1'b0;
    {fan_pump_variant, motor2_select, thermal_warn, coef_write} = 4'h0;
    early_warning_select = SEL_CURRENT;
    cur_cmd = 16'h0000;
    freq_cmd = 16'h0000;
    overload_warn_level = 16'h03e8;
    second_current_level = 16'h07d0;
    second_freq_level = 16'h1770;
    freq_detect_hysteresis = 16'h01f4;
    overload_warn_delay = 10'h001;
    display_scale_a_in = 18'sd0;
    display_scale_b_in = 18'sd0;
    pid_target = 14'h2710;
    pid_feedback = 14'h0000;
    cy(6);
    chk("reset scale a", 32'h64, display_scale_a);
    chk("reset scale b", 32'h0, display_scale_b);
    rstn = 1'b1;
    cy(2);
    chk("reset warn", 32'h0, overload_warn);
    $display("t_reset done");
    t_warn();
    t_block();
    t_levels();
    t_coef();
    report_and_stop();
  end
endmodule
